// >>> sld_device.sv
/*
  device end: samples the serial link, shifts 36-bit frames, latches 35 segment outputs.
  assumes the host keeps frame shape and rate; link pins are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_device #(
  parameter bit GATE_VARIANT = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  sld_link_if.dev link,
  output logic [sld_pkg::DATA_BITS-1:0] o_seg
);
  import sld_pkg::*;
  // ****************************************
  // input synchronisers
  // ****************************************
  logic sclk_s;
  logic sdata_s;
  logic gate_n_s;
  sld_sync u_sync_clk (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(link.sclk), .i_init(1'b0), .o_sync(sclk_s));
  sld_sync u_sync_dat (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(link.sdata), .i_init(1'b0), .o_sync(sdata_s));
  sld_sync u_sync_gat (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(link.data_gate_n), .i_init(1'b1),
    .o_sync(gate_n_s));
  // ****************************************
  // shift chain and latches
  // ****************************************
  // the lead one walks down from the top; when it sits in stage 1 the frame is full
  logic [FRAME_BITS-1:0] chain;
  logic [FRAME_BITS-1:0] next_chain;
  logic [DATA_BITS-1:0] next_seg;
  logic sclk_d;
  logic next_sclk_d;
  logic clr_pend;
  logic next_clr_pend;
  logic rise;
  logic fall;
  logic gate_ok;
  always_comb begin
    rise = sclk_s & ~sclk_d;
    fall = ~sclk_s & sclk_d;
    gate_ok = ~GATE_VARIANT | ~gate_n_s;
    next_sclk_d = sclk_s;
    next_chain = chain;
    next_seg = o_seg;
    next_clr_pend = clr_pend;
    if (i_rst) begin
      next_chain = '0;
      next_seg = LATCH_RESET;
      next_clr_pend = 1'b0;
      next_sclk_d = 1'b0;
    end else if (rise && gate_ok) begin
      // shift toward the lead stage; data enters at the top, so bit 1 ends at index 1
      next_chain = {sdata_s, chain[FRAME_BITS-1:1]};
      if (chain[1]) begin
        // lead one sits in stage 1 on the 36th clock: load during clock high
        // bit k waits in stage k+2; the last bit is still on the line
        next_seg = {sdata_s, chain[FRAME_BITS-1:2]};
        if (GATE_VARIANT) begin
          next_seg[DATA_BITS-1] = 1'b0;
        end
        next_chain = '0;
        next_clr_pend = 1'b1;
      end
    end else if (fall && clr_pend) begin
      // clear on clock low; the first stage master is a fresh sample taken next rise
      next_chain = '0;
      next_clr_pend = 1'b0;
    end
  end
  always_ff @(posedge i_mclk) begin
    sclk_d <= next_sclk_d;
    chain <= next_chain;
    o_seg <= next_seg;
    clr_pend <= next_clr_pend;
  end
endmodule : sld_device
`default_nettype wire

// >>> sld_host.sv
/*
  host end: sends one 36-bit frame per request, clock made by a divider.
  assumes the device samples on the rising serial clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_host (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [sld_pkg::DATA_BITS-1:0] i_data,
  output logic o_busy,
  sld_link_if.host link
);
  import sld_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} sld_hstate_t;
  sld_hstate_t state;
  sld_hstate_t next_state;
  logic [FRAME_BITS-1:0] sh;
  logic [FRAME_BITS-1:0] next_sh;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [5:0] bits;
  logic [5:0] next_bits;
  logic sclk;
  logic next_sclk;
  logic gate_n;
  logic next_gate_n;
  logic next_busy;
  always_comb begin
    next_state = state;
    next_sh = sh;
    next_cnt = cnt;
    next_bits = bits;
    next_sclk = sclk;
    if (i_rst) begin
      next_state = ST_IDLE;
      next_sh = '0;
      next_cnt = '0;
      next_bits = '0;
      next_sclk = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            next_sh = {i_data, 1'b1};
            next_bits = 6'(FRAME_BITS);
            next_cnt = '0;
            next_state = ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt == CNT_W'(HALF_CYCLES - 1)) begin
            next_cnt = '0;
            next_sclk = 1'b1;
            next_state = ST_HIGH;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        ST_HIGH: begin
          if (cnt == CNT_W'(HALF_CYCLES - 1)) begin
            next_cnt = '0;
            next_sclk = 1'b0;
            next_sh = {1'b0, sh[FRAME_BITS-1:1]};
            next_bits = bits - 1'b1;
            next_state = (bits == 6'h01) ? ST_IDLE : ST_LOW;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    next_busy = (next_state != ST_IDLE);
    // gate opens only while a frame runs, so stray line noise between frames is ignored
    next_gate_n = (next_state == ST_IDLE);
  end
  always_ff @(posedge i_mclk) begin
    state <= next_state;
    sh <= next_sh;
    cnt <= next_cnt;
    bits <= next_bits;
    sclk <= next_sclk;
    gate_n <= next_gate_n;
    o_busy <= next_busy;
  end
  assign link.sclk = sclk;
  assign link.sdata = sh[0];
  assign link.data_gate_n = gate_n;
endmodule : sld_host
`default_nettype wire

// >>> sld_link_chk.sv
/*
  checker on the serial link wires between host and device ends.
  assumes it sits beside the link interface in the bench top.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_link_chk (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic data_gate_n
);
  import sld_pkg::*;
  // ****
  // rise counter, wraps after a whole frame
  // ****
  logic sclk_q, next_sclk_q;
  logic [5:0] cnt, next_cnt;
  always_comb begin
    next_sclk_q = sclk;
    next_cnt = cnt;
    if (sclk && !sclk_q) begin
      next_cnt = (cnt == 6'(FRAME_BITS - 1)) ? 6'h00 : cnt + 6'h01;
    end
  end
  always_ff @(posedge i_mclk) begin
    sclk_q <= i_rst ? 1'b0 : next_sclk_q;
    cnt <= i_rst ? 6'h00 : next_cnt;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_rst_idle; $fell(i_rst) |-> !sclk && !sdata && data_gate_n; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
  property p_gate; sclk |-> !data_gate_n; endproperty
  a_gate: assert property (p_gate) else $error("gate not held low");
  property p_high; $rose(sclk) |-> ##49 sclk; endproperty
  a_high: assert property (p_high) else $error("serial clock high too short");
  property p_low; $fell(sclk) |-> ##49 !sclk; endproperty
  a_low: assert property (p_low) else $error("serial clock low too short");
  property p_stab; sclk |-> $stable(sdata); endproperty
  a_stab: assert property (p_stab) else $error("data moved while clock high");
  property p_lead; $rose(sclk) && cnt == 6'h00 |-> sdata; endproperty
  a_lead: assert property (p_lead) else $error("lead bit not one");
  property p_mid; $fell(sclk) && cnt != 6'h00 |-> ##[1:60] sclk; endproperty
  a_mid: assert property (p_mid) else $error("frame stopped early");
  property p_chg; $changed(sdata) |-> !sclk; endproperty
  a_chg: assert property (p_chg) else $error("data edge in clock high");
endmodule : sld_link_chk
`default_nettype wire

// >>> sld_link_if.sv
/*
  interface joining the host end and the device end: clock, data, gate.
  assumes both ends share the system clock domain for bench convenience.
*/
`timescale 1ns/1ns
`default_nettype none
interface sld_link_if;
  logic sclk;
  logic sdata;
  logic data_gate_n;
  modport host (output sclk, output sdata, output data_gate_n);
  modport dev (input sclk, input sdata, input data_gate_n);
endinterface : sld_link_if
`default_nettype wire

// >>> sld_pkg.sv
/*
  constants for the serial led segment latch driver link: frame shape, timing counts.
  assumes a 50 MHz system clock on both ends.
*/
`default_nettype none
// Summary of operation
// - host drives clock, data and gate lines
// - frame is lead one then 35 bits
// - latch data only after 36th bit
// - latch pulse on clock-high after 36th bit
// - clear pulse on following clock-low phase
// - clear spares first stage master, back-to-back
// - host always sends full 36 clocks
// - power-up reset clears chain and latches
// - resume on lead bit with first clock
// - first data bit drives output one
// - latched one turns segment on
// - outputs hold until next latch transfer
// - gate variant: gate replaces 35th output
// - serial clock no faster than 0.5 MHz
package sld_pkg;
  localparam int DATA_BITS = 35;
  localparam int FRAME_BITS = DATA_BITS + 1;
  localparam int SYS_CLK_NS = 20;
  // serial clock half period: 950 ns least, rounded up; 1000 ns keeps 0.5 MHz
  localparam int HALF_PERIOD_NS = 1000;
  localparam int HALF_CYCLES = (HALF_PERIOD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [DATA_BITS-1:0] LATCH_RESET = 35'h0_0000_0000;
endpackage : sld_pkg
`default_nettype wire

// >>> sld_sync.sv
/*
  two flop synchroniser for one level input.
  assumes the input is asynchronous to i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_sync (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_async,
  input wire logic i_init,
  output logic o_sync
);
  logic meta;
  logic next_meta;
  logic next_sync;
  always_comb begin
    next_meta = i_rst ? i_init : i_async;
    next_sync = i_rst ? i_init : meta;
  end
  always_ff @(posedge i_mclk) begin
    meta <= next_meta;
    o_sync <= next_sync;
  end
endmodule : sld_sync
`default_nettype wire

// >>> testbench.sv
/*
  bench: host and both device variants on one link, frames checked against a model.
  assumes the design files and checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sld_pkg::*;
  // ****
  // harness
  // ****
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic [DATA_BITS-1:0] i_data = '0;
  logic o_busy;
  logic [DATA_BITS-1:0] o_seg, o_seg_g, prev;
  logic [DATA_BITS-1:0] prev_g;
  logic gate_blk = 1'b0;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [DATA_BITS-1:0] pat[$] = {35'h0_0000_0001, 35'h7_ffff_ffff, 35'h7_ffff_ffff, 35'h0_0000_0000};
  always #10 i_mclk = ~i_mclk;
  sld_link_if link ();
  // the gated device sees the host lines; the bench can also hold its gate shut
  sld_link_if link_g ();
  assign link_g.sclk = link.sclk;
  assign link_g.sdata = link.sdata;
  assign link_g.data_gate_n = link.data_gate_n | gate_blk;
  sld_host u_sld_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start), .i_data(i_data), .o_busy(o_busy), .link(link));
  sld_device u_sld_device (.i_mclk(i_mclk), .i_rst(i_rst), .link(link), .o_seg(o_seg));
  sld_device #(.GATE_VARIANT(1'b1)) u_sld_device_gate (.i_mclk(i_mclk), .i_rst(i_rst), .link(link_g), .o_seg(o_seg_g));
  sld_link_chk u_sld_link_chk (.i_mclk(i_mclk), .i_rst(i_rst), .sclk(link.sclk), .sdata(link.sdata),
    .data_gate_n(link.data_gate_n));
  task automatic chk(input string n, input logic [DATA_BITS-1:0] e, input logic [DATA_BITS-1:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic wait_busy(input logic v);
    for (int k = 0; k < 4000 && o_busy !== v; k++) @(negedge i_mclk);
  endtask : wait_busy
  // model: bit i of the frame data lands on output i (gated device: output 34 held zero), latched only at frame end
  task automatic send(input logic [DATA_BITS-1:0] d, input logic blk);
    i_data = d;
    gate_blk = blk;
    i_start = 1'b1;
    wait_busy(1'b1);
    i_start = 1'b0;
    repeat (1700) @(negedge i_mclk);
    chk("seg_hold", prev, o_seg);
    chk("seg_hold_gate", prev_g, o_seg_g);
    wait_busy(1'b0);
    repeat (60) @(negedge i_mclk);
    chk("seg", d, o_seg);
    if (!blk) begin
      prev_g = {1'b0, d[DATA_BITS-2:0]};
    end
    chk("seg_gate", prev_g, o_seg_g);
    prev = d;
    gate_blk = 1'b0;
  endtask : send
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 50000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(15));
    prev = '0;
    prev_g = '0;
    repeat (10) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    chk("seg_rst", prev, o_seg);
    chk("seg_rst_gate", prev_g, o_seg_g);
    for (int i = 0; i < 2; i++) pat.push_back(DATA_BITS'({$urandom, $urandom}));
    foreach (pat[i]) send(pat[i], 1'b0);
    // a frame under a shut gate must leave the gated outputs and chain alone
    send(DATA_BITS'({$urandom, $urandom}), 1'b1);
    send(35'h2_aaaa_aaaa, 1'b0);
    // second reset in mid-run, then a frame must still land
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    prev = '0;
    prev_g = '0;
    chk("seg_rst2", prev, o_seg);
    chk("seg_rst2_gate", prev_g, o_seg_g);
    send(35'h5_5555_5555, 1'b0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
